// [pkg/pbmcs_pkg.sv]
// Constants and types for the basic control and status register pair
package pbmcs_pkg;
    // Register addresses on the management bus
    localparam logic [4:0] REG_CONTROL = 5'h00;
    localparam logic [4:0] REG_STATUS = 5'h01;
    localparam logic [4:0] REG_VENDOR = 5'h11;
    // Control field positions
    localparam int CTL_SRST = 15;
    localparam int CTL_LOOP = 14;
    localparam int CTL_PD = 11;
    localparam int CTL_ISO = 10;
    // Fixed read values and vendor register reset value
    localparam logic CTL_SPEED_VAL = 1'h1;
    localparam logic CTL_ANEG_VAL = 1'h0;
    localparam logic [9:0] CTL_RSVD_VAL = 10'h100;
    localparam logic [15:0] VENDOR_RST = 16'h0000;
    // Status field positions
    localparam int STS_PRE_SUPP = 6;
    localparam int STS_ANEG_DONE = 5;
    localparam int STS_RFAULT = 4;
    localparam int STS_LINK = 2;
    localparam int STS_JABBER = 1;
    localparam int STS_EXT_CAP = 0;
    // Management frame constants
    localparam logic [5:0] PRE_LEN = 6'h20;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [4:0] ADDR_BITS_LAST = 5'h09;
    localparam logic [4:0] DATA_BITS_LAST = 5'h0F;
    // Soft reset duration
    localparam int SYS_CLK_PERIOD_NS = 50;
    localparam int SRST_TIME_NS = 1000;
    localparam int SRST_CYC_INT = (SRST_TIME_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam logic [4:0] SRST_LOAD = 5'(SRST_CYC_INT - 1);

    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_ST = 6'h02,
        S_OP = 6'h04,
        S_ADDR = 6'h08,
        S_TA = 6'h10,
        S_DATA = 6'h20
    } pbmcs_state_t;

    typedef struct packed {
        pbmcs_state_t state;
        logic mdc_q;
        logic [5:0] pre_cnt;
        logic pre_ok;
        logic [4:0] bit_cnt;
        logic [1:0] op;
        logic [15:0] shift;
        logic mine;
        logic [4:0] regad;
        logic mdo;
        logic mdo_oe;
        logic ctl_srst;
        logic [4:0] srst_cnt;
        logic ctl_loop;
        logic ctl_pd;
        logic ctl_iso;
        logic [15:0] vendor;
        logic rf_lat;
        logic jab_lat;
        logic link_lost;
        logic [3:0] rx_d;
        logic rx_dv;
        logic [3:0] line_tx_d;
        logic line_tx_en;
        logic link_up;
    } pbmcs_regs_t;
endpackage

// [rtl/pbmcs_top.sv]
// Basic control/status registers with management frame slave and MAC data gating
// Behaviour
// - Writing one to soft reset bit resets coding-layer registers to defaults.
// - Soft reset bit reads one during reset, clears itself when done.
// - Soft reset leaves vendor-specific register untouched.
// - Loopback bit routes MAC transmit data back onto MAC receive lines.
// - No link-up indication while MAC-side loopback is active.
// - Speed bit reads one, auto-negotiation enable reads zero, both read-only.
// - Power down bit places the physical layer into low-power state.
// - Powered down keeps management access working, disables everything else.
// - Effective power down is power down bit OR active-low pin.
// - Pin driven low sets the power down bit.
// - Isolate bit disconnects MAC data interface, management stays working.
// - Remote fault latches high on fault, clears on read or reset.
// - Link status reads one only with valid link, latches low until read.
// - Frames without preamble accepted; full preamble needed after reset or errors.
module pbmcs_top
    import pbmcs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [4:0] phy_addr,
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe,
    input wire logic interrupt_powerdown_pin_n,
    input wire logic [3:0] mac_tx_d,
    input wire logic mac_tx_en,
    output logic [3:0] mac_rx_d,
    output logic mac_rx_dv,
    input wire logic [3:0] line_rx_d,
    input wire logic line_rx_dv,
    output logic [3:0] line_tx_d,
    output logic line_tx_en,
    input wire logic link_ok,
    input wire logic remote_fault_in,
    input wire logic jabber_in,
    output logic link_up,
    output logic power_down,
    output logic pcs_reset,
    output logic [15:0] vendor_cfg
);
    import pbmcs_pkg::*;

    localparam pbmcs_regs_t Q_RESET = '{
        state: S_IDLE, mdc_q: 1'h0, pre_cnt: 6'h00, pre_ok: 1'h0, bit_cnt: 5'h00,
        op: 2'h0, shift: 16'h0000, mine: 1'h0, regad: 5'h00, mdo: 1'h0, mdo_oe: 1'h0,
        ctl_srst: 1'h0, srst_cnt: 5'h00, ctl_loop: 1'h0, ctl_pd: 1'h0, ctl_iso: 1'h0,
        vendor: VENDOR_RST, rf_lat: 1'h0, jab_lat: 1'h0, link_lost: 1'h1,
        rx_d: 4'h0, rx_dv: 1'h0, line_tx_d: 4'h0, line_tx_en: 1'h0, link_up: 1'h0
    };

    pbmcs_regs_t q;
    pbmcs_regs_t n;
    logic mdc_rise;
    logic pd_eff;
    logic link_live;
    logic data_off;

    function automatic logic reg_hit(input logic [4:0] a, input logic [4:0] o);
        return a == o;
    endfunction

    assign mdc_rise = mdc & ~q.mdc_q;
    assign pd_eff = q.ctl_pd | ~interrupt_powerdown_pin_n;
    // Soft reset also holds the data path quiet
    assign data_off = pd_eff | q.ctl_srst;
    assign link_live = link_ok & ~q.ctl_loop & ~data_off;

    always_comb begin
        logic clr_sts;
        logic srst_go;
        logic [9:0] full;
        logic [15:0] wd;
        logic [15:0] rd;
        clr_sts = 1'b0;
        srst_go = 1'b0;
        full = {q.shift[8:0], mdio_in};
        wd = {q.shift[14:0], mdio_in};
        rd = 16'h0000;
        n = q;
        n.mdc_q = mdc;

        // Soft reset countdown
        if (q.ctl_srst) begin
            if (q.srst_cnt == 5'h00) begin
                n.ctl_srst = 1'b0;
            end else begin
                n.srst_cnt = q.srst_cnt - 5'h01;
            end
        end

        if (mdc_rise) begin
            case (q.state)
                S_IDLE: begin
                    if (mdio_in) begin
                        if (q.pre_cnt == PRE_LEN - 6'h01) begin
                            n.pre_ok = 1'b1;
                        end else begin
                            n.pre_cnt = q.pre_cnt + 6'h01;
                        end
                    end else begin
                        n.pre_cnt = 6'h00;
                        // Start bit only counts once a full preamble was seen
                        if (q.pre_ok) begin
                            n.pre_ok = 1'b1;
                            n.state = S_ST;
                        end
                    end
                end
                S_ST: begin
                    n.bit_cnt = 5'h00;
                    n.state = mdio_in ? S_OP : S_IDLE;
                end
                S_OP: begin
                    n.op = {q.op[0], mdio_in};
                    if (q.bit_cnt == 5'h01) begin
                        n.bit_cnt = 5'h00;
                        if ({q.op[0], mdio_in} == OP_READ || {q.op[0], mdio_in} == OP_WRITE) begin
                            n.state = S_ADDR;
                        end else begin
                            n.pre_ok = 1'b0;
                            n.state = S_IDLE;
                        end
                    end else begin
                        n.bit_cnt = 5'h01;
                    end
                end
                S_ADDR: begin
                    n.shift = wd;
                    n.bit_cnt = q.bit_cnt + 5'h01;
                    if (q.bit_cnt == ADDR_BITS_LAST) begin
                        n.bit_cnt = 5'h00;
                        n.mine = full[9:5] == phy_addr;
                        n.regad = full[4:0];
                        n.state = S_TA;
                        if (reg_hit(full[4:0], REG_CONTROL)) begin
                            rd = {q.ctl_srst, q.ctl_loop, CTL_SPEED_VAL, CTL_ANEG_VAL,
                                  q.ctl_pd, q.ctl_iso, CTL_RSVD_VAL};
                        end else if (reg_hit(full[4:0], REG_STATUS)) begin
                            rd = 16'h0000;
                            rd[STS_PRE_SUPP] = 1'b1;
                            rd[STS_ANEG_DONE] = 1'b1;
                            rd[STS_RFAULT] = q.rf_lat;
                            rd[STS_LINK] = link_live & ~q.link_lost;
                            rd[STS_JABBER] = q.jab_lat;
                            rd[STS_EXT_CAP] = 1'b1;
                            clr_sts = (full[9:5] == phy_addr) && (q.op == OP_READ);
                        end else if (reg_hit(full[4:0], REG_VENDOR)) begin
                            rd = q.vendor;
                        end
                        if (q.op == OP_READ) begin
                            n.shift = rd;
                        end
                    end
                end
                S_TA: begin
                    n.bit_cnt = 5'h01;
                    if (q.op == OP_READ) begin
                        if (q.bit_cnt == 5'h00) begin
                            n.mdo_oe = q.mine;
                            n.mdo = 1'b0;
                        end else begin
                            n.mdo = q.shift[15];
                            n.shift = {q.shift[14:0], 1'b0};
                            n.bit_cnt = 5'h00;
                            n.state = S_DATA;
                        end
                    end else if (mdio_in != (q.bit_cnt == 5'h00)) begin
                        // Bad turnaround on a write drops the frame
                        n.pre_ok = 1'b0;
                        n.state = S_IDLE;
                    end else if (q.bit_cnt == 5'h01) begin
                        n.bit_cnt = 5'h00;
                        n.state = S_DATA;
                    end
                end
                S_DATA: begin
                    n.bit_cnt = q.bit_cnt + 5'h01;
                    if (q.op == OP_READ) begin
                        n.mdo = q.shift[15];
                        n.shift = {q.shift[14:0], 1'b0};
                    end else begin
                        n.shift = wd;
                    end
                    if (q.bit_cnt == DATA_BITS_LAST) begin
                        n.mdo_oe = 1'b0;
                        n.mdo = 1'b0;
                        n.state = S_IDLE;
                        n.pre_cnt = 6'h00;
                        if (q.op == OP_WRITE && q.mine) begin
                            if (reg_hit(q.regad, REG_CONTROL)) begin
                                // Read-only and reserved bits are not stored
                                n.ctl_loop = wd[CTL_LOOP];
                                n.ctl_pd = wd[CTL_PD];
                                n.ctl_iso = wd[CTL_ISO];
                                if (wd[CTL_SRST]) begin
                                    srst_go = 1'b1;
                                    n.ctl_srst = 1'b1;
                                    n.srst_cnt = SRST_LOAD;
                                    n.ctl_loop = 1'b0;
                                    n.ctl_pd = 1'b0;
                                    n.ctl_iso = 1'b0;
                                end
                            end else if (reg_hit(q.regad, REG_VENDOR)) begin
                                n.vendor = wd;
                            end
                        end
                    end
                end
                default: begin
                    n.state = S_IDLE;
                    n.mdo_oe = 1'b0;
                end
            endcase
        end

        // Latches: a new event wins over a clear in the same cycle
        n.rf_lat = remote_fault_in | (q.rf_lat & ~clr_sts & ~srst_go);
        n.jab_lat = jabber_in | (q.jab_lat & ~clr_sts & ~srst_go);
        n.link_lost = ~link_live | (q.link_lost & ~clr_sts);
        if (!interrupt_powerdown_pin_n) begin
            n.ctl_pd = 1'b1;
        end

        // MAC data path
        if (data_off || q.ctl_iso) begin
            n.rx_d = 4'h0;
            n.rx_dv = 1'b0;
        end else if (q.ctl_loop) begin
            n.rx_d = mac_tx_d;
            n.rx_dv = mac_tx_en;
        end else begin
            n.rx_d = line_rx_d;
            n.rx_dv = line_rx_dv;
        end
        n.line_tx_d = (data_off || q.ctl_iso) ? 4'h0 : mac_tx_d;
        n.line_tx_en = mac_tx_en & ~data_off & ~q.ctl_iso;
        n.link_up = link_live;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= Q_RESET;
        end else begin
            q <= n;
        end
    end

    assign mdio_out = q.mdo;
    assign mdio_oe = q.mdo_oe;
    assign mac_rx_d = q.rx_d;
    assign mac_rx_dv = q.rx_dv;
    assign line_tx_d = q.line_tx_d;
    assign line_tx_en = q.line_tx_en;
    assign link_up = q.link_up;
    assign power_down = pd_eff;
    assign pcs_reset = q.ctl_srst;
    assign vendor_cfg = q.vendor;

    // Checks
    a_srst_self_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(q.ctl_srst) |-> ##19 q.ctl_srst ##1 !q.ctl_srst)
        else $error("soft reset length wrong");
    a_srst_ctl_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(q.ctl_srst) && $past(interrupt_powerdown_pin_n) |-> !q.ctl_loop && !q.ctl_pd)
        else $error("soft reset kept control bits");
    a_loop_data: assert property (@(posedge sys_clk) disable iff (!rst_n)
        q.ctl_loop && !data_off && !q.ctl_iso |=> mac_rx_dv == $past(mac_tx_en))
        else $error("loopback data mismatch");
    a_loop_no_link: assert property (@(posedge sys_clk) disable iff (!rst_n)
        q.ctl_loop |=> !link_up)
        else $error("link up during loopback");
    a_pin_sets_pd: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !interrupt_powerdown_pin_n |=> q.ctl_pd && power_down)
        else $error("pin did not set power down");
    a_pd_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
        pd_eff |=> !mac_rx_dv && !line_tx_en && !link_up)
        else $error("data active in power down");
    a_iso_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
        q.ctl_iso |=> !mac_rx_dv && !line_tx_en)
        else $error("data active while isolated");
    a_rf_latch: assert property (@(posedge sys_clk) disable iff (!rst_n)
        remote_fault_in |=> q.rf_lat)
        else $error("remote fault not latched");
    a_link_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !link_live |=> q.link_lost)
        else $error("link loss not latched");
    a_ta_drive: assert property (@(posedge sys_clk) disable iff (!rst_n)
        mdc_rise && q.state == S_TA && q.op == OP_READ && q.mine && q.bit_cnt == 5'h00
        |=> mdio_oe && !mdio_out)
        else $error("read turnaround not driven");
    c_read: cover property (@(posedge sys_clk) disable iff (!rst_n)
        q.state == S_DATA && q.op == OP_READ && q.mine);
    c_srst: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(q.ctl_srst));
    c_loop: cover property (@(posedge sys_clk) disable iff (!rst_n) q.ctl_loop && mac_rx_dv);
    a_srst_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
        q.ctl_srst |=> !link_up && !line_tx_en && !mac_rx_dv)
        else $error("data active during soft reset");
    c_pin_pd: cover property (@(posedge sys_clk) disable iff (!rst_n) !interrupt_powerdown_pin_n);
endmodule

// [dv/pbmcs_smi_master.sv]
// Management bus master model that drives frames into the register pair
module pbmcs_smi_master (
    input wire logic sys_clk,
    output logic mdc,
    output logic mdio_m,
    output logic mdio_m_oe,
    input wire logic mdio_wire
);
    timeunit 1ns;
    timeprecision 1ns;
    import pbmcs_pkg::*;
    initial begin
        mdc = 1'b0;
        mdio_m = 1'b1;
        mdio_m_oe = 1'b0;
    end
    // Two cycles low, two high; line sampled well after the last output change
    task automatic slot(input logic b, input logic drv, output logic s);
        @(posedge sys_clk);
        mdc <= 1'b0;
        mdio_m <= b;
        mdio_m_oe <= drv;
        @(posedge sys_clk);
        // Mid-cycle sample, away from the edges on which the device moves the line
        @(negedge sys_clk);
        s = mdio_wire;
        @(posedge sys_clk);
        mdc <= 1'b1;
        @(posedge sys_clk);
    endtask
    task automatic frame(input logic pre, input logic [1:0] op, input logic [4:0] phy,
                         input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
        logic [31:0] f;
        logic s;
        f = {2'b01, op, phy, ra, 2'b10, wd};
        if (pre) begin
            for (int i = 0; i < 32; i++) slot(1'b1, 1'b1, s);
        end
        for (int i = 31; i >= 0; i--) begin
            // Released from turnaround on for reads so the device can answer
            slot(f[i], (op != OP_READ) || (i > 17), s);
            if (i < 16) rd[i] = s;
        end
        @(posedge sys_clk);
        mdc <= 1'b0;
        mdio_m_oe <= 1'b0;
    endtask
endmodule

// [dv/tb_phy_basic_mode_control_status.sv]
// Self-checking bench for the basic control and status register pair
module tb_phy_basic_mode_control_status;
    timeunit 1ns;
    timeprecision 1ns;
    import pbmcs_pkg::*;
    localparam logic [4:0] PHY = 5'h03;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic mdc, mdio_m, mdio_m_oe, mdio_out, mdio_oe, mdio_wire;
    logic pin_n = 1'b1;
    logic [3:0] mac_tx_d = 4'h0;
    logic mac_tx_en = 1'b0;
    logic [3:0] line_rx_d = 4'h0;
    logic line_rx_dv = 1'b0;
    logic link_ok = 1'b1;
    logic remote_fault_in = 1'b0;
    logic jabber_in = 1'b0;
    logic [3:0] mac_rx_d, line_tx_d;
    logic mac_rx_dv, line_tx_en, link_up, power_down, pcs_reset;
    logic [15:0] vendor_cfg;
    int n_errors = 0;
    int compares = 0;
    always #25 sys_clk = ~sys_clk;
    // Pull-up on the shared data line
    assign mdio_wire = mdio_oe ? mdio_out : (mdio_m_oe ? mdio_m : 1'b1);
    pbmcs_top i_pbmcs_top (.sys_clk(sys_clk), .rst_n(rst_n), .phy_addr(PHY), .mdc(mdc),
        .mdio_in(mdio_wire), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
        .interrupt_powerdown_pin_n(pin_n), .mac_tx_d(mac_tx_d), .mac_tx_en(mac_tx_en),
        .mac_rx_d(mac_rx_d), .mac_rx_dv(mac_rx_dv), .line_rx_d(line_rx_d),
        .line_rx_dv(line_rx_dv), .line_tx_d(line_tx_d), .line_tx_en(line_tx_en),
        .link_ok(link_ok), .remote_fault_in(remote_fault_in), .jabber_in(jabber_in),
        .link_up(link_up), .power_down(power_down), .pcs_reset(pcs_reset),
        .vendor_cfg(vendor_cfg));
    pbmcs_smi_master i_pbmcs_smi_master (.sys_clk(sys_clk), .mdc(mdc), .mdio_m(mdio_m),
        .mdio_m_oe(mdio_m_oe), .mdio_wire(mdio_wire));
    task automatic close_out();
        if (n_errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [4:0] ra, input logic [15:0] d);
        logic [15:0] x;
        i_pbmcs_smi_master.frame(1'b0, OP_WRITE, PHY, ra, d, x);
    endtask
    task automatic rchk(input string what, input logic [4:0] ra, input logic [15:0] exp);
        logic [15:0] d;
        i_pbmcs_smi_master.frame(1'b0, OP_READ, PHY, ra, 16'hFFFF, d);
        chk(what, d, exp);
    endtask
    task automatic t_defaults();
        logic [15:0] d;
        i_pbmcs_smi_master.frame(1'b1, OP_READ, PHY, REG_CONTROL, 16'hFFFF, d);
        chk("ctl reset", d, 16'h2100);
        rchk("sts first", REG_STATUS, 16'h0061);
        rchk("sts live", REG_STATUS, 16'h0065);
        wr(REG_CONTROL, 16'h13FF);
        rchk("ctl fixed", REG_CONTROL, 16'h2100);
    endtask
    task automatic t_loop_iso();
        wr(REG_CONTROL, 16'h4000);
        @(posedge sys_clk);
        mac_tx_d <= 4'hA;
        mac_tx_en <= 1'b1;
        step(2);
        chk("loop rx", {11'h0, mac_rx_dv, mac_rx_d}, 16'h001A);
        chk("loop link", {15'h0, link_up}, 16'h0000);
        wr(REG_CONTROL, 16'h0400);
        @(posedge sys_clk);
        line_rx_d <= 4'h5;
        line_rx_dv <= 1'b1;
        step(2);
        chk("iso rx", {11'h0, mac_rx_dv, mac_rx_d}, 16'h0000);
        chk("iso link", {15'h0, link_up}, 16'h0001);
        rchk("iso ctl", REG_CONTROL, 16'h2500);
        wr(REG_CONTROL, 16'h0000);
        step(2);
        chk("norm rx", {11'h0, mac_rx_dv, mac_rx_d}, 16'h0015);
    endtask
    task automatic t_power();
        wr(REG_CONTROL, 16'h0800);
        step(2);
        chk("pd out", {9'h0, power_down, link_up, line_tx_en, line_tx_d}, 16'h0040);
        rchk("pd ctl", REG_CONTROL, 16'h2900);
        wr(REG_CONTROL, 16'h0000);
        step(2);
        chk("pd off", {9'h0, power_down, link_up, line_tx_en, line_tx_d}, 16'h003A);
        @(posedge sys_clk);
        pin_n <= 1'b0;
        step(1);
        chk("pin pd", {15'h0, power_down}, 16'h0001);
        @(posedge sys_clk);
        pin_n <= 1'b1;
        step(2);
        rchk("pin bit", REG_CONTROL, 16'h2900);
        wr(REG_CONTROL, 16'h0000);
    endtask
    task automatic t_soft_reset();
        int n;
        wr(REG_VENDOR, 16'hA5C3);
        wr(REG_CONTROL, 16'hC000);
        step(0);
        for (n = 0; n < 5 && pcs_reset !== 1'b1; n++) step(1);
        if (n == 5) begin
            n_errors++;
            close_out();
        end
        for (n = 0; n < 40 && pcs_reset === 1'b1; n++) step(1);
        // Reset rose one edge before the write frame returned
        chk("srst len", 16'(n + 1), 16'(SRST_CYC_INT));
        rchk("srst ctl", REG_CONTROL, 16'h2100);
        chk("vendor pin", vendor_cfg, 16'hA5C3);
        rchk("vendor rd", REG_VENDOR, 16'hA5C3);
    endtask
    task automatic t_latches();
        logic [15:0] d;
        @(posedge sys_clk);
        remote_fault_in <= 1'b1;
        jabber_in <= 1'b1;
        link_ok <= 1'b0;
        @(posedge sys_clk);
        remote_fault_in <= 1'b0;
        jabber_in <= 1'b0;
        link_ok <= 1'b1;
        rchk("sts latched", REG_STATUS, 16'h0073);
        rchk("sts after", REG_STATUS, 16'h0065);
        // Bad opcode drops sync; a frame without preamble must then be ignored
        i_pbmcs_smi_master.frame(1'b0, 2'b00, PHY, REG_CONTROL, 16'h0000, d);
        rchk("no pre", REG_VENDOR, 16'hFFFF);
        i_pbmcs_smi_master.frame(1'b1, OP_READ, PHY, REG_VENDOR, 16'hFFFF, d);
        chk("with pre", d, 16'hA5C3);
        // Frames for another address are followed but never answered or stored
        i_pbmcs_smi_master.frame(1'b0, OP_WRITE, 5'h04, REG_VENDOR, 16'h1234, d);
        rchk("other wr", REG_VENDOR, 16'hA5C3);
        i_pbmcs_smi_master.frame(1'b0, OP_READ, 5'h04, REG_CONTROL, 16'hFFFF, d);
        chk("other rd", d, 16'hFFFF);
    endtask
    initial begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        step(2);
        t_defaults();
        t_loop_iso();
        t_power();
        t_soft_reset();
        t_latches();
        close_out();
    end
endmodule
